// ===== anr_pkg.sv
// Notes on behaviour
// - Local advertisement register, 16 bits, read/write, register index 4.
// - Advertisement bit 15 advertises next page, writable, resets to zero.
// - Advertisement bit 13 advertises remote fault, writable, resets to zero.
// - Advertisement bit 11 advertises asymmetric pause, writable, resets to zero.
// - Advertisement bit 10 advertises symmetric pause, writable, resets to zero.
// - Advertisement bit 8, 100BASE-X full duplex, writable, resets to one.
// - Advertisement bits 7, 6, 5: 100X half, 10T full, 10T half.
// - Advertisement bits 4:0 selector, writable, resets to the IEEE 802.3 code.
// - Partner ability register, 16 bits, read-only, index 5, selector resets 00001.
// - Partner bit 15 shows partner next page ability, resets to zero.
// - Partner bit 14 reads one from a received link code word until the next exchange start clears it.
// - Partner bit 13 shows partner remote fault, resets to zero.
// - Partner bit 12 shows partner extended next page, resets to zero.
// - Partner bits 11 and 10 show asymmetric and symmetric pause, reset zero.
// - Partner bit 9 shows partner 100BASE-T4 ability, resets to zero.
// - Partner bits 8 to 5 show partner speed and duplex abilities.
// - Partner bit 10 is the plain symmetric pause flag, separate from local bits.
package anr_pkg;
   localparam int          ANR_AW         = 8;
   localparam int          ANR_DW         = 32;
   localparam int          ANR_RW         = 16;
   localparam logic [5:0]  ANR_IDX_ADV    = 6'h04;
   localparam logic [5:0]  ANR_IDX_LP     = 6'h05;
   localparam logic [5:0]  ANR_IDX_STAT   = 6'h10;
   localparam logic [15:0] ANR_ADV_WMASK  = 16'hbdff;
   localparam logic [15:0] ANR_ADV_RST    = 16'h0101;
   localparam logic [15:0] ANR_LP_RST     = 16'h0001;
   localparam int          ANR_LP_ACK_BIT = 14;
   localparam int          ANR_ST_PEND    = 0;
   localparam int          ANR_ST_ACK     = 1;
   localparam logic [1:0]  ANR_RESP_OKAY  = 2'h0;
   localparam logic [1:0]  ANR_RESP_SLVERR = 2'h2;
endpackage

// ===== anr_page_if.sv
`timescale 1ns/1ps
`default_nettype none
interface anr_page_if;
   logic        page_valid;
   logic [15:0] page_word;
   logic        an_start;
   logic [15:0] partner_word;
   modport capture (input page_valid, input page_word, input an_start, output partner_word);
   modport owner (output page_valid, output page_word, output an_start, input partner_word);
endinterface
`default_nettype wire

// ===== anr_partner_capture.sv
`timescale 1ns/1ps
`default_nettype none
module anr_partner_capture
   import anr_pkg::*;
(
   input  wire logic   clk_in,
   input  wire logic   rst_n_in,
   anr_page_if.capture pg
);
   import anr_pkg::*;

   logic [15:0] lp_ff;
   logic [15:0] nxt_lp;

   // A page arriving with a restart keeps its acknowledge bit: the load wins.
   always_comb begin
      nxt_lp = lp_ff;
      if (pg.an_start) begin
         nxt_lp[ANR_LP_ACK_BIT] = 1'b0;
      end
      if (pg.page_valid) begin
         nxt_lp                 = pg.page_word;
         nxt_lp[ANR_LP_ACK_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lp_ff <= ANR_LP_RST;
      end else begin
         lp_ff <= nxt_lp;
      end
   end

   assign pg.partner_word = lp_ff;
endmodule // anr_partner_capture
`default_nettype wire

// ===== anr_regs.sv
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module anr_regs
   import anr_pkg::*;
(
   input  wire logic                 ref_clk_in,
   input  wire logic                 nrst_in,
   input  wire logic [ANR_AW-1:0]    avs_address_in,
   input  wire logic                 avs_read_in,
   input  wire logic                 avs_write_in,
   input  wire logic [ANR_DW-1:0]    avs_writedata_in,
   input  wire logic [3:0]           avs_byteenable_in,
   output logic [ANR_DW-1:0]         avs_readdata_out,
   output logic                      avs_waitrequest_out,
   output logic [1:0]                avs_response_out,
   input  wire logic                 an_start_in,
   input  wire logic                 rx_page_valid_in,
   input  wire logic [ANR_RW-1:0]    rx_page_in,
   output logic [ANR_RW-1:0]         adv_word_out,
   output logic                      adv_pending_out
);
   import anr_pkg::*;

   logic [1:0]        rst_sync_ff;
   logic              rst_n;
   logic              wait_ff;
   logic [ANR_DW-1:0] rdata_ff;
   logic [1:0]        resp_ff;
   logic [15:0]       adv_ff;
   logic [15:0]       snap_ff;
   logic              pend_ff;
   logic              req;
   logic              accept;
   logic              done;
   logic [15:0]       lane_mask;
   logic [15:0]       nxt_adv;
   logic [ANR_DW-1:0] nxt_rdata;
   logic [1:0]        nxt_resp;

   anr_page_if pg ();

   // Registers are decoded from word indices; the byte address is four times the index.
   function automatic logic reg_hit(input logic [ANR_AW-1:0] addr, input logic [5:0] want);
      reg_hit = (addr[ANR_AW-1:2] == want) && (addr[1:0] == 2'h0);
   endfunction

   function automatic logic [15:0] lanes(input logic [3:0] be);
      lanes = {{8{be[1]}}, {8{be[0]}}};
   endfunction

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   assign req       = avs_read_in | avs_write_in;
   assign accept    = req & wait_ff;
   assign done      = req & ~wait_ff;
   assign lane_mask = lanes(avs_byteenable_in);

   // Every request is answered one cycle after it is seen, so a master never stalls long.
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         wait_ff <= 1'b1;
      end else begin
         wait_ff <= ~accept;
      end
   end

   always_comb begin
      nxt_adv = adv_ff;
      // A write lands only at the edge where waitrequest is low, so a held request lands once.
      if (done && avs_write_in && reg_hit(avs_address_in, ANR_IDX_ADV)) begin
         // Reserved bits 14 and 9 never store, so they always read zero.
         nxt_adv = (adv_ff & ~(ANR_ADV_WMASK & lane_mask)) |
                   (avs_writedata_in[15:0] & ANR_ADV_WMASK & lane_mask);
      end
   end

   // Bit 12 stays writable; keeping it zero is left to software.
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         adv_ff <= ANR_ADV_RST;
      end else begin
         adv_ff <= nxt_adv;
      end
   end

   // The negotiation logic only sees a snapshot taken when an exchange starts.
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         snap_ff <= ANR_ADV_RST;
      end else if (an_start_in) begin
         snap_ff <= adv_ff;
      end
   end

   // A write that changes the register in the same cycle as a start keeps the pending flag set.
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         pend_ff <= 1'b0;
      end else if (nxt_adv != adv_ff) begin
         pend_ff <= 1'b1;
      end else if (an_start_in) begin
         pend_ff <= 1'b0;
      end
   end

   assign pg.page_valid = rx_page_valid_in;
   assign pg.page_word  = rx_page_in;
   assign pg.an_start   = an_start_in;

   anr_partner_capture u_capture (
      .clk_in   (ref_clk_in),
      .rst_n_in (rst_n),
      .pg       (pg)
   );

   always_comb begin
      nxt_rdata = '0;
      nxt_resp  = ANR_RESP_OKAY;
      if (reg_hit(avs_address_in, ANR_IDX_ADV)) begin
         nxt_rdata[15:0] = adv_ff;
      end else if (reg_hit(avs_address_in, ANR_IDX_LP)) begin
         nxt_rdata[15:0] = pg.partner_word;
      end else if (reg_hit(avs_address_in, ANR_IDX_STAT)) begin
         nxt_rdata[ANR_ST_PEND] = pend_ff;
         nxt_rdata[ANR_ST_ACK]  = pg.partner_word[ANR_LP_ACK_BIT];
      end else begin
         nxt_resp = ANR_RESP_SLVERR;
      end
      if (!avs_read_in) begin
         nxt_rdata = '0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
         resp_ff  <= ANR_RESP_OKAY;
      end else if (accept) begin
         rdata_ff <= nxt_rdata;
         resp_ff  <= nxt_resp;
      end else begin
         rdata_ff <= '0;
         resp_ff  <= ANR_RESP_OKAY;
      end
   end

   assign avs_waitrequest_out = wait_ff;
   assign avs_readdata_out    = rdata_ff;
   assign avs_response_out    = resp_ff;
   assign adv_word_out        = snap_ff;
   assign adv_pending_out     = pend_ff;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n);

   property p_wait_low;
      accept |=> !wait_ff ##1 wait_ff;
   endproperty
   a_wait_low: assert property (p_wait_low) else $error("no one-cycle answer");

   property p_adv_write;
      (done && avs_write_in && reg_hit(avs_address_in, ANR_IDX_ADV)
       && avs_byteenable_in == 4'hf)
      |=> adv_ff == ($past(avs_writedata_in[15:0]) & ANR_ADV_WMASK);
   endproperty
   a_adv_write: assert property (p_adv_write) else $error("advert write lost");

   property p_rsvd_zero;
      adv_ff[14] == 1'b0 && adv_ff[9] == 1'b0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

   property p_adv_read;
      (accept && avs_read_in && reg_hit(avs_address_in, ANR_IDX_ADV))
      |=> avs_readdata_out == {16'h0000, adv_ff} && !avs_waitrequest_out;
   endproperty
   a_adv_read: assert property (p_adv_read) else $error("advert read wrong");

   property p_lp_read;
      (accept && avs_read_in && reg_hit(avs_address_in, ANR_IDX_LP) && !rx_page_valid_in)
      |=> avs_readdata_out[15:0] == $past(pg.partner_word);
   endproperty
   a_lp_read: assert property (p_lp_read) else $error("partner read wrong");

   property p_lp_ro;
      (avs_write_in && !rx_page_valid_in && !an_start_in) |=> $stable(pg.partner_word);
   endproperty
   a_lp_ro: assert property (p_lp_ro) else $error("partner changed by write");

   property p_page_load;
      rx_page_valid_in |=> pg.partner_word[15] == $past(rx_page_in[15])
                           && pg.partner_word[13:0] == $past(rx_page_in[13:0]);
   endproperty
   a_page_load: assert property (p_page_load) else $error("page not loaded");

   property p_page_ack;
      (rx_page_valid_in || (pg.partner_word[ANR_LP_ACK_BIT] && !an_start_in))
      |=> pg.partner_word[ANR_LP_ACK_BIT];
   endproperty
   a_page_ack: assert property (p_page_ack) else $error("acknowledge dropped");

   property p_snap;
      an_start_in |=> adv_word_out == $past(adv_ff);
   endproperty
   a_snap: assert property (p_snap) else $error("snapshot wrong");

   property p_snap_hold;
      !an_start_in |=> $stable(adv_word_out);
   endproperty
   a_snap_hold: assert property (p_snap_hold) else $error("advert changed early");

   property p_unmapped;
      (accept && avs_read_in && !reg_hit(avs_address_in, ANR_IDX_ADV)
       && !reg_hit(avs_address_in, ANR_IDX_LP) && !reg_hit(avs_address_in, ANR_IDX_STAT))
      |=> avs_response_out == ANR_RESP_SLVERR && avs_readdata_out == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");

   c_adv_write: cover property (accept && avs_write_in && reg_hit(avs_address_in, ANR_IDX_ADV));
   c_lp_read: cover property (accept && avs_read_in && reg_hit(avs_address_in, ANR_IDX_LP));
   c_page: cover property (rx_page_valid_in ##1 an_start_in);
   c_pend: cover property ($rose(adv_pending_out) ##[1:100] $fell(adv_pending_out));
endmodule // anr_regs
`default_nettype wire

// ===== anr_lp_model.sv
`timescale 1ns/1ps
`default_nettype none
// Link partner as seen from the receiver: one base page per send request.
module anr_lp_model (
   input  wire logic        clk_in,
   input  wire logic        send_in,
   input  wire logic [15:0] word_in,
   output logic             page_valid_out,
   output logic [15:0]      page_word_out
);
   initial begin
      page_valid_out = 1'b0;
      page_word_out  = 16'h0000;
   end
   always @(posedge clk_in) begin
      page_valid_out <= send_in;
   end
   // Outside a page the word toggles every cycle, so stale data is never mistaken for valid.
   always @(posedge clk_in) begin
      if (send_in) begin
         page_word_out <= word_in;
      end else begin
         page_word_out <= ~page_word_out;
      end
   end
endmodule // anr_lp_model
`default_nettype wire

// ===== autoneg_ability_registers_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module autoneg_ability_registers_tb_top;
   import anr_pkg::*;
   logic        clk   = 1'b0;
   logic        nrst  = 1'b0;
   logic        rd    = 1'b0;
   logic        wrs   = 1'b0;
   logic        start = 1'b0;
   logic        snd   = 1'b0;
   logic [7:0]  addr  = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [15:0] sword = 16'h0;
   logic [3:0]  be    = 4'hf;
   logic [31:0] rdata;
   logic        wreq;
   logic [1:0]  resp;
   logic [15:0] adv_word;
   logic        adv_pend;
   logic        pvalid;
   logic [15:0] pword;
   logic [31:0] q;
   logic [1:0]  r;
   int          n_errors = 0;
   int          n_tests  = 0;
   int          cyc      = 0;
   logic [15:0] rows [5][2] = '{'{16'hedff, 16'hadff}, '{16'h4200, 16'h0000},
      '{16'h0501, 16'h0501}, '{16'h80e1, 16'h80e1}, '{16'h2800, 16'h2800}};

   anr_regs dut (.ref_clk_in(clk), .nrst_in(nrst), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wrs), .avs_writedata_in(wdata),
      .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
      .avs_response_out(resp), .an_start_in(start), .rx_page_valid_in(pvalid),
      .rx_page_in(pword), .adv_word_out(adv_word), .adv_pending_out(adv_pend));
   anr_lp_model lp (.clk_in(clk), .send_in(snd), .word_in(sword),
      .page_valid_out(pvalid), .page_word_out(pword));

   initial begin
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Called just after a rising edge; returns just after one, with the bus idle.
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
      addr  <= a;
      rd    <= ~w;
      wrs   <= w;
      wdata <= {16'h0000, d};
      // Only the bench timeout ends a wait that never sees waitrequest low.
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      q = rdata;
      r = resp;
      rd  <= 1'b0;
      wrs <= 1'b0;
      @(posedge clk);
   endtask

   task automatic page(input logic [15:0] w);
      sword <= w;
      snd   <= 1'b1;
      @(posedge clk);
      snd <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic kick();
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         print_verdict();
      end
   end

   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      chk("adv_word reset", 32'h0101, {16'h0, adv_word});
      chk("pending reset", 32'h0, {31'h0, adv_pend});
      bus(1'b0, 8'h10, 16'h0);
      chk("adv reset", 32'h0000_0101, q);
      bus(1'b0, 8'h14, 16'h0);
      chk("partner reset", 32'h0000_0001, q);
      // Software keeps the extended next page bit at zero in every write.
      foreach (rows[i]) begin
         bus(1'b1, 8'h10, rows[i][0]);
         chk("pending set", 32'h1, {31'h0, adv_pend});
         bus(1'b0, 8'h10, 16'h0);
         chk("adv readback", {16'h0, rows[i][1]}, q);
         chk("adv resp", 32'h0, {30'h0, r});
      end
      chk("snapshot held", 32'h0101, {16'h0, adv_word});
      kick();
      chk("snapshot new", 32'h2800, {16'h0, adv_word});
      chk("pending clear", 32'h0, {31'h0, adv_pend});
      page(16'hbbe1);
      bus(1'b0, 8'h14, 16'h0);
      chk("partner load", 32'h0000_fbe1, q);
      bus(1'b1, 8'h14, 16'h0000);
      chk("partner wr resp", 32'h0, {30'h0, r});
      bus(1'b0, 8'h14, 16'h0);
      chk("partner ro", 32'h0000_fbe1, q);
      page(16'h0401);
      kick();
      bus(1'b0, 8'h14, 16'h0);
      chk("ack cleared", 32'h0000_0401, q);
      be <= 4'h1;
      bus(1'b1, 8'h10, 16'h00ff);
      be <= 4'hf;
      bus(1'b0, 8'h10, 16'h0);
      chk("adv lane write", 32'h0000_28ff, q);
      bus(1'b0, 8'h40, 16'h0);
      chk("status", 32'h0000_0001, q);
      bus(1'b0, 8'h20, 16'h0);
      chk("unmapped resp", 32'h2, {30'h0, r});
      chk("unmapped data", 32'h0, q);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      bus(1'b0, 8'h14, 16'h0);
      chk("partner rereset", 32'h0000_0001, q);
      print_verdict();
   end
endmodule // autoneg_ability_registers_tb_top
`default_nettype wire
